// ---- core/mdb_pkg.sv ----
// constants, codes and layouts for the auxiliary microprocessor datapath
// assumes one 100 MHz clock and a host that reaches the block over APB
package mdb_pkg;
    // APB byte offsets of the four host words
    localparam logic [11:0] OFS_WORD0 = 12'h000;
    localparam logic [11:0] OFS_WORD1 = 12'h004;
    localparam logic [11:0] OFS_WORD2 = 12'h008;
    localparam logic [11:0] OFS_WORD3 = 12'h00C;

    // microinstruction fields
    localparam int I_BRANCH = 15;
    localparam int I_COMBINE = 14;
    localparam int I_SRC_LO = 11;
    localparam int I_DST_LO = 8;
    localparam int I_BR_ALWAYS = 10;
    localparam int I_PAGE_LO = 8;
    localparam int I_SUB_LO = 4;
    localparam int I_SUB_WIN = 7;

    localparam logic [2:0] SRC_BRANCH_REG = 3'h0;
    localparam logic [2:0] SRC_PORT_WIN = 3'h1;
    localparam logic [2:0] SRC_CSR_WIN = 3'h2;
    localparam logic [2:0] SRC_EXT = 3'h3;
    localparam logic [2:0] SRC_DATA_MEM = 3'h4;
    localparam logic [2:0] SRC_IMM = 3'h5;
    localparam logic [2:0] SRC_FLAGS = 3'h6;
    localparam logic [2:0] SRC_ADDR_HI = 3'h7;

    localparam logic [2:0] DST_NONE = 3'h0;
    localparam logic [2:0] DST_BRANCH_REG = 3'h1;
    localparam logic [2:0] DST_ADDR_LO = 3'h2;
    localparam logic [2:0] DST_ADDR_HI = 3'h3;
    localparam logic [2:0] DST_DATA_MEM = 3'h4;
    localparam logic [2:0] DST_OUT_SPACE = 3'h5;
    localparam logic [2:0] DST_SCRATCH = 3'h6;
    localparam logic [2:0] DST_ADDR_INC = 3'h7;

    localparam logic [1:0] ALU_ADD = 2'h0;
    localparam logic [1:0] ALU_SUB = 2'h1;
    localparam logic [1:0] ALU_AND = 2'h2;
    localparam logic [1:0] ALU_OR = 2'h3;

    // port window byte layout
    localparam logic [2:0] PW_ADDR_LO = 3'h0;
    localparam logic [2:0] PW_ADDR_HI = 3'h1;
    localparam logic [2:0] PW_DATA_LO = 3'h2;
    localparam logic [2:0] PW_DATA_HI = 3'h3;
    localparam logic [2:0] PW_XFER_CTL = 3'h4;
    localparam logic [2:0] PW_MISC = 3'h5;
    localparam logic [2:0] PW_EXT_OUT = 3'h6;

    localparam int XC_REQ = 0;
    localparam int XC_OUT = 1;
    localparam int XC_XADDR_LO = 2;
    localparam int XC_DONE = 7;
    localparam int MISC_XADDR_LO = 2;

    // control bits in the upper byte of host word zero
    localparam int CTL_MI_LOAD = 0;
    localparam int CTL_STEP = 1;
    localparam int CTL_ADDR_SEL = 2;
    localparam int CTL_PC_VIEW = 4;
    localparam int CTL_STORE_WR = 5;
    localparam int CTL_MCLR = 6;
    localparam int CTL_RUN = 7;

    localparam logic [9:0] PC_RST = 10'h000;
    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    typedef enum logic {DMA_IDLE, DMA_WAIT} mdb_dma_e;
endpackage : mdb_pkg

// ---- core/mdb_datapath.sv ----
// source/destination datapath, host window, store load path and direct transfer sequencer
// assumes an APB master on the host side and a bus agent answering dmaReq with dmaAck
`timescale 1ns/1ns
module mdb_datapath (
    input wire logic clk, // 100 MHz
    input wire logic rst_n, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    input wire logic [7:0] extIn, // external connector in
    output logic [7:0] extOut, // external connector out
    output logic dmaReq, // transfer request
    output logic dmaWrite, // 1 output transfer, 0 input
    output logic [17:0] dmaAddr, // bus address
    output logic [15:0] dmaWdata, // output transfer data
    input wire logic dmaAck, // transfer finished
    input wire logic [15:0] dmaRdata, // input transfer data
    output logic running // run bit logic
);
    logic [15:0] ctlStore [0:1023];
    logic [7:0] dataMem [0:1023];
    logic [7:0] scratch [0:15];
    logic [7:0] csrWin_r [0:7];
    logic [7:0] csrWin_nxt [0:7];
    logic [7:0] portWin_r [0:7];
    logic [7:0] portWin_nxt [0:7];
    logic [9:0] pc_r, pc_nxt, memAddr_r, memAddr_nxt, maintAddr_r, maintAddr_nxt;
    logic [7:0] branchOperand_r, branchOperand_nxt, ctl_r, ctl_nxt;
    logic [15:0] maintInstr_r, maintInstr_nxt;
    logic carry_r, carry_nxt, zero_r, zero_nxt;
    logic stepPrev_r, stepPrev_nxt, wrPrev_r, wrPrev_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    mdb_pkg::mdb_dma_e dmaState_r, dmaState_nxt;
    logic dmaReq_r, dmaReq_nxt, dmaWrite_r, dmaWrite_nxt, dmaDone;
    logic [17:0] dmaAddr_r, dmaAddr_nxt;
    logic [15:0] dmaWdata_r, dmaWdata_nxt;

    logic hostAcc, hostHit, mclr, stepPulse, storeWrPulse, exec, taken;
    logic [1:0] hostWord;
    logic [15:0] instr, rdWord;
    logic [3:0] sub;
    logic [7:0] aOp, bOp, aluRes, xferCtl;
    logic aluC;
    logic [2:0] dst;
    logic moveWr;

    function automatic logic [8:0] mdb_alu(input logic [1:0] op, input logic [7:0] a, input logic [7:0] b);
        logic [8:0] r;
        r = 9'h000;
        case (op)
            mdb_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
            // carry reads as not-borrow on subtraction
            mdb_pkg::ALU_SUB: r = {1'b1, a} - {1'b0, b};
            mdb_pkg::ALU_AND: r = {1'b0, a & b};
            default: r = {1'b0, a | b};
        endcase
        return r;
    endfunction : mdb_alu

    // host side: decode, control bits, maintenance registers, read data
    always_comb begin
        hostAcc = psel & penable & pready_r;
        hostHit = 1'b1;
        hostWord = 2'h0;
        if (paddr == mdb_pkg::OFS_WORD0) begin
            hostWord = 2'h0;
        end else if (paddr == mdb_pkg::OFS_WORD1) begin
            hostWord = 2'h1;
        end else if (paddr == mdb_pkg::OFS_WORD2) begin
            hostWord = 2'h2;
        end else if (paddr == mdb_pkg::OFS_WORD3) begin
            hostWord = 2'h3;
        end else begin
            hostHit = 1'b0;
        end
        mclr = hostAcc & pwrite & hostHit & (hostWord == 2'h0) & pstrb[1] & pwdata[8 + mdb_pkg::CTL_MCLR];
        ctl_nxt = ctl_r;
        maintAddr_nxt = maintAddr_r;
        maintInstr_nxt = maintInstr_r;
        if (hostAcc & pwrite & hostHit & (hostWord == 2'h0) & pstrb[1]) begin
            // the control logic follows host writes only, never microprogram writes
            ctl_nxt = pwdata[15:8];
            ctl_nxt[mdb_pkg::CTL_MCLR] = 1'b0;
        end
        if (hostAcc & pwrite & hostHit & (hostWord == 2'h2) & ctl_r[mdb_pkg::CTL_ADDR_SEL]) begin
            maintAddr_nxt = pwdata[9:0];
        end
        if (hostAcc & pwrite & hostHit & (hostWord == 2'h3) & ctl_r[mdb_pkg::CTL_MI_LOAD]) begin
            maintInstr_nxt = pwdata[15:0];
        end
        if (mclr) begin
            ctl_nxt = mdb_pkg::BYTE_RST;
            maintInstr_nxt = mdb_pkg::WORD_RST;
        end
        stepPulse = ctl_r[mdb_pkg::CTL_STEP] & ~stepPrev_r & ~ctl_r[mdb_pkg::CTL_RUN];
        storeWrPulse = ctl_r[mdb_pkg::CTL_STORE_WR] & ~wrPrev_r & ctl_r[mdb_pkg::CTL_ADDR_SEL];
        stepPrev_nxt = ctl_r[mdb_pkg::CTL_STEP];
        wrPrev_nxt = ctl_r[mdb_pkg::CTL_STORE_WR];
        rdWord = {csrWin_r[{hostWord, 1'b1}], csrWin_r[{hostWord, 1'b0}]};
        if ((hostWord == 2'h3) & ctl_r[mdb_pkg::CTL_ADDR_SEL]) begin
            rdWord = ctlStore[maintAddr_r];
        end else if ((hostWord == 2'h3) & ctl_r[mdb_pkg::CTL_MI_LOAD]) begin
            rdWord = maintInstr_r;
        end else if ((hostWord == 2'h3) & ctl_r[mdb_pkg::CTL_PC_VIEW]) begin
            rdWord = ctlStore[pc_r];
        end
        // one wait state so read data leaves a flip-flop
        pready_nxt = psel & penable & ~pready_r;
        pslverr_nxt = psel & penable & ~pready_r & ~hostHit;
        prdata_nxt = prdata_r;
        if (psel & penable & ~pready_r) begin
            prdata_nxt = hostHit ? {16'h0000, rdWord} : 32'h0000_0000;
        end
    end

    // execution of one microinstruction per cycle
    always_comb begin
        instr = stepPulse ? maintInstr_r : ctlStore[pc_r];
        exec = ctl_r[mdb_pkg::CTL_RUN] | stepPulse;
        sub = instr[mdb_pkg::I_SUB_LO +: 4];
        dst = instr[mdb_pkg::I_DST_LO +: 3];
        aOp = scratch[sub];
        case (instr[mdb_pkg::I_SRC_LO +: 3])
            mdb_pkg::SRC_BRANCH_REG: bOp = branchOperand_r;
            mdb_pkg::SRC_PORT_WIN: bOp = portWin_r[sub[2:0]];
            mdb_pkg::SRC_CSR_WIN: bOp = csrWin_r[sub[2:0]];
            mdb_pkg::SRC_EXT: bOp = extIn;
            mdb_pkg::SRC_DATA_MEM: bOp = dataMem[memAddr_r];
            mdb_pkg::SRC_IMM: bOp = instr[7:0];
            mdb_pkg::SRC_FLAGS: bOp = {6'h00, carry_r, zero_r};
            default: bOp = {6'h00, memAddr_r[9:8]};
        endcase
        // combine with scratch pad or pass the source through unchanged
        {aluC, aluRes} = instr[mdb_pkg::I_COMBINE] ? mdb_alu(instr[1:0], aOp, bOp) : {1'b0, bOp};
        taken = instr[mdb_pkg::I_BRANCH] & (instr[mdb_pkg::I_BR_ALWAYS] | zero_r);
        moveWr = exec & ~instr[mdb_pkg::I_BRANCH];
        pc_nxt = pc_r;
        if (exec & ~stepPulse) begin
            pc_nxt = pc_r + 10'h001;
            if (taken) begin
                pc_nxt = {instr[mdb_pkg::I_PAGE_LO +: 2], aluRes};
            end
        end
        memAddr_nxt = memAddr_r;
        branchOperand_nxt = branchOperand_r;
        carry_nxt = carry_r;
        zero_nxt = zero_r;
        if (moveWr & instr[mdb_pkg::I_COMBINE]) begin
            carry_nxt = aluC;
            zero_nxt = (aluRes == mdb_pkg::ALL_ONES);
        end
        if (moveWr) begin
            case (dst)
                mdb_pkg::DST_BRANCH_REG: branchOperand_nxt = aluRes;
                mdb_pkg::DST_ADDR_LO: memAddr_nxt[7:0] = aluRes;
                mdb_pkg::DST_ADDR_HI: memAddr_nxt[9:8] = aluRes[1:0];
                mdb_pkg::DST_ADDR_INC: memAddr_nxt = memAddr_r + 10'h001;
                default: memAddr_nxt = memAddr_r;
            endcase
        end
        if (mclr) begin
            pc_nxt = mdb_pkg::PC_RST;
            memAddr_nxt = mdb_pkg::ADDR_RST;
            branchOperand_nxt = mdb_pkg::BYTE_RST;
            carry_nxt = 1'b0;
            zero_nxt = 1'b0;
        end
    end

    // shared windows: microprogram, host and transfer sequencer all write here
    always_comb begin
        csrWin_nxt = csrWin_r;
        portWin_nxt = portWin_r;
        if (moveWr & (dst == mdb_pkg::DST_OUT_SPACE)) begin
            if (sub[3]) begin
                csrWin_nxt[sub[2:0]] = aluRes;
            end else begin
                portWin_nxt[sub[2:0]] = aluRes;
            end
        end
        // host wins a same-byte collision; the handshake keeps this from mattering
        for (int k = 0; k < 2; k++) begin
            if (hostAcc & pwrite & hostHit & pstrb[k]) begin
                csrWin_nxt[{hostWord, k[0]}] = pwdata[8 * k +: 8];
            end
        end
        xferCtl = portWin_nxt[mdb_pkg::PW_XFER_CTL];
        if (dmaDone) begin
            // completion sets the done bit over a microprogram write; a request bit written in the same cycle is kept
            xferCtl[mdb_pkg::XC_DONE] = 1'b1;
            xferCtl[mdb_pkg::XC_REQ] = moveWr & (dst == mdb_pkg::DST_OUT_SPACE) &
                (sub == {1'b0, mdb_pkg::PW_XFER_CTL}) & aluRes[mdb_pkg::XC_REQ];
            if (~dmaWrite_r) begin
                portWin_nxt[mdb_pkg::PW_DATA_LO] = dmaRdata[7:0];
                portWin_nxt[mdb_pkg::PW_DATA_HI] = dmaRdata[15:8];
            end
        end
        portWin_nxt[mdb_pkg::PW_XFER_CTL] = xferCtl;
        if (mclr) begin
            // the pending request survives a master clear
            portWin_nxt[mdb_pkg::PW_XFER_CTL] = {7'h00, xferCtl[mdb_pkg::XC_REQ]};
            portWin_nxt[mdb_pkg::PW_MISC] = mdb_pkg::BYTE_RST;
        end
    end

    // direct transfer sequencer, independent of instruction flow
    always_comb begin
        dmaState_nxt = dmaState_r;
        dmaReq_nxt = dmaReq_r;
        dmaWrite_nxt = dmaWrite_r;
        dmaAddr_nxt = dmaAddr_r;
        dmaWdata_nxt = dmaWdata_r;
        dmaDone = 1'b0;
        case (dmaState_r)
            mdb_pkg::DMA_IDLE: begin
                if (portWin_r[mdb_pkg::PW_XFER_CTL][mdb_pkg::XC_REQ]) begin
                    dmaState_nxt = mdb_pkg::DMA_WAIT;
                    dmaReq_nxt = 1'b1;
                    dmaWrite_nxt = portWin_r[mdb_pkg::PW_XFER_CTL][mdb_pkg::XC_OUT];
                    dmaAddr_nxt[15:0] = {portWin_r[mdb_pkg::PW_ADDR_HI], portWin_r[mdb_pkg::PW_ADDR_LO]};
                    dmaAddr_nxt[17:16] = portWin_r[mdb_pkg::PW_XFER_CTL][mdb_pkg::XC_OUT] ?
                        portWin_r[mdb_pkg::PW_MISC][mdb_pkg::MISC_XADDR_LO +: 2] :
                        portWin_r[mdb_pkg::PW_XFER_CTL][mdb_pkg::XC_XADDR_LO +: 2];
                    dmaWdata_nxt = {portWin_r[mdb_pkg::PW_DATA_HI], portWin_r[mdb_pkg::PW_DATA_LO]};
                end
            end
            default: begin
                if (dmaAck) begin
                    dmaState_nxt = mdb_pkg::DMA_IDLE;
                    dmaReq_nxt = 1'b0;
                    dmaDone = 1'b1;
                end
            end
        endcase
    end

    // store and memories carry no reset; contents survive master clear
    always_ff @(posedge clk) begin
        if (storeWrPulse) begin
            ctlStore[maintAddr_r] <= {csrWin_r[7], csrWin_r[6]};
        end
        if (moveWr & (dst == mdb_pkg::DST_DATA_MEM)) begin
            dataMem[memAddr_r] <= aluRes;
        end
        if (moveWr & (dst == mdb_pkg::DST_SCRATCH)) begin
            scratch[sub] <= aluRes;
        end
    end

    // host side registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_r <= mdb_pkg::BYTE_RST;
            maintAddr_r <= mdb_pkg::ADDR_RST;
            maintInstr_r <= mdb_pkg::WORD_RST;
            stepPrev_r <= 1'b0;
            wrPrev_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            ctl_r <= ctl_nxt;
            maintAddr_r <= maintAddr_nxt;
            maintInstr_r <= maintInstr_nxt;
            stepPrev_r <= stepPrev_nxt;
            wrPrev_r <= wrPrev_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // instruction state: program counter, address register, branch operand, flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_r <= mdb_pkg::PC_RST;
            memAddr_r <= mdb_pkg::ADDR_RST;
            branchOperand_r <= mdb_pkg::BYTE_RST;
            carry_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            memAddr_r <= memAddr_nxt;
            branchOperand_r <= branchOperand_nxt;
            carry_r <= carry_nxt;
            zero_r <= zero_nxt;
        end
    end

    // shared window bytes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                csrWin_r[i] <= mdb_pkg::BYTE_RST;
                portWin_r[i] <= mdb_pkg::BYTE_RST;
            end
        end else begin
            csrWin_r <= csrWin_nxt;
            portWin_r <= portWin_nxt;
        end
    end

    // transfer sequencer registers, kept apart so instruction flow never stalls them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dmaState_r <= mdb_pkg::DMA_IDLE;
            dmaReq_r <= 1'b0;
            dmaWrite_r <= 1'b0;
            dmaAddr_r <= 18'h00000;
            dmaWdata_r <= mdb_pkg::WORD_RST;
        end else begin
            dmaState_r <= dmaState_nxt;
            dmaReq_r <= dmaReq_nxt;
            dmaWrite_r <= dmaWrite_nxt;
            dmaAddr_r <= dmaAddr_nxt;
            dmaWdata_r <= dmaWdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign extOut = portWin_r[mdb_pkg::PW_EXT_OUT];
    assign dmaReq = dmaReq_r;
    assign dmaWrite = dmaWrite_r;
    assign dmaAddr = dmaAddr_r;
    assign dmaWdata = dmaWdata_r;
    assign running = ctl_r[mdb_pkg::CTL_RUN];
endmodule : mdb_datapath

// ---- bench/mdb_monitor.sv ----
// checker: host bus timing, refusal and direct transfer handshake
// assumes bind onto mdb_datapath, seeing its ports only
`timescale 1ns/1ns
module mdb_monitor (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [3:0] pstrb, // strobes
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [7:0] extIn, // connector in
    input wire logic [7:0] extOut, // connector out
    input wire logic dmaReq, // transfer request
    input wire logic dmaWrite, // direction
    input wire logic [17:0] dmaAddr, // bus address
    input wire logic [15:0] dmaWdata, // output data
    input wire logic dmaAck, // answer
    input wire logic [15:0] dmaRdata, // input data
    input wire logic running // run bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_sel: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_err_decode: assert property (pready |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
        else $error("error flag does not match address");
    a_err_data: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("refused access returned data");
    a_rdata_hi: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_req_hold: assert property (dmaReq && !dmaAck |=> dmaReq && $stable(dmaAddr) && $stable(dmaWdata)
        && $stable(dmaWrite))
        else $error("transfer request changed before answer");
    a_req_drop: assert property (dmaReq && dmaAck |=> !dmaReq)
        else $error("request stayed after answer");
    a_reset_quiet: assert property ($rose(rst_n) |-> !dmaReq && !running && !pready && extOut == 8'h00)
        else $error("outputs not quiet after reset");
endmodule : mdb_monitor

bind mdb_datapath mdb_monitor mdb_monitor_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .extIn, .extOut, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata, .running);

// ---- bench/mdb_bus_agent.sv ----
// bus agent answering direct transfers after a set number of cycles
// assumes dmaReq stays up until the edge that samples dmaAck
`timescale 1ns/1ns
module mdb_bus_agent (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic dmaReq, // request
    input wire logic dmaWrite, // direction
    input wire logic [17:0] dmaAddr, // address
    input wire logic [15:0] dmaWdata, // output data
    input wire logic [7:0] ackDelay, // wait cycles
    output logic dmaAck, // answer
    output logic [15:0] dmaRdata, // input data
    output logic [17:0] lastAddr, // seen address
    output logic [15:0] lastData, // seen data
    output logic lastWrite // seen direction
);
    logic [7:0] cnt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dmaAck <= 1'b0;
            cnt <= 8'h00;
            dmaRdata <= 16'h5A5A;
        end else if (dmaReq && !dmaAck && cnt == ackDelay) begin
            dmaAck <= 1'b1;
            dmaRdata <= ~dmaAddr[15:0];
            lastAddr <= dmaAddr;
            lastData <= dmaWdata;
            lastWrite <= dmaWrite;
            cnt <= 8'h00;
        end else begin
            dmaAck <= 1'b0;
            cnt <= (dmaReq && !dmaAck) ? cnt + 8'h01 : 8'h00;
            dmaRdata <= ~dmaRdata; // toggles so stale data never looks valid
        end
    end
endmodule : mdb_bus_agent

// ---- bench/tb_top.sv ----
// bench: host word accesses, store loading, stepped instructions, direct transfers
// assumes one wait state per host access and a stepped instruction done within four cycles
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t %h %h", $time, g, e); end end
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, dmaReq, dmaWrite, dmaAck, running, err, lastWrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] extIn, extOut, ackDelay;
    logic [17:0] dmaAddr, lastAddr;
    logic [15:0] dmaWdata, dmaRdata, lastData;
    logic [15:0] prog [8] = '{16'h2D65, 16'h1D60, 16'h2E6F, 16'h6D60, 16'h6D62, 16'h2A07, 16'h2C99, 16'h2560};
    logic [7:0] expOut [8] = '{8'h65, 8'h3C, 8'h00, 8'hCF, 8'h62, 8'h00, 8'h00, 8'h99};
    logic [15:0] xout [6] = '{16'h2D03, 16'h2D12, 16'h2D2A, 16'h2D3B, 16'h2D5C, 16'h2D43};
    logic [9:0] runAddr [3] = '{10'h001, 10'h3FE, 10'h3FF};
    logic [15:0] runProg [3] = '{16'hAFFE, 16'h2D67, 16'hAFFF};
    int num_errors, compares, n;
    mdb_datapath mdb_datapath_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .extIn, .extOut, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata, .running);
    mdb_bus_agent mdb_bus_agent_i (.clk, .rst_n, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata, .ackDelay, .dmaAck,
        .dmaRdata, .lastAddr, .lastData, .lastWrite);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim;
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // programmed accesses with caller-chosen byte strobes
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_sim();
        end
        @(posedge clk);
    endtask : apb
    // one maintenance step; control bits then instruction word, in order
    task automatic exec(input logic [15:0] ins);
        apb(1'b1, 12'h000, 32'h0100, 4'h2);
        apb(1'b1, 12'h00C, {16'h0, ins}, 4'h3);
        apb(1'b1, 12'h000, 32'h0300, 4'h2);
        apb(1'b1, 12'h000, 32'h0000, 4'h2);
    endtask : exec
    task automatic sel_addr(input logic [9:0] a);
        apb(1'b1, 12'h000, 32'h0400, 4'h2);
        apb(1'b1, 12'h008, {22'h0, a}, 4'h3);
    endtask : sel_addr
    task automatic wait_idle;
        n = 0;
        while (dmaReq !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            end_sim();
        end
    endtask : wait_idle
    initial begin
        num_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        extIn = 8'h3C;
        ackDelay = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({running, dmaReq, extOut}, 10'h000)
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h004, 32'h1234, 4'h3);
        apb(1'b1, 12'h004, 32'hBEEF, 4'h1);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK({err, rd}, {1'b0, 32'h12EF})
        for (int i = 0; i < 2; i++) begin
            sel_addr(i ? 10'h3FF : 10'h000);
            apb(1'b1, 12'h00C, i ? 32'hA5C3 : 32'h2D65, 4'h3);
            apb(1'b1, 12'h000, 32'h2400, 4'h2);
        end
        for (int i = 0; i < 2; i++) begin
            sel_addr(i ? 10'h3FF : 10'h000);
            apb(1'b0, 12'h00C, 32'h0, 4'h0);
            `CHK(rd, i ? 32'hA5C3 : 32'h2D65)
        end
        apb(1'b1, 12'h000, 32'h1000, 4'h2);
        apb(1'b0, 12'h00C, 32'h0, 4'h0);
        `CHK(rd, 32'h2D65)
        for (int i = 0; i < 8; i++) begin
            exec(prog[i]);
            if (prog[i][10:4] == 7'h56) `CHK(extOut, expOut[i])
        end
        foreach (xout[i]) exec(xout[i]);
        wait_idle();
        `CHK({lastWrite, lastAddr, lastData}, {1'b1, 18'h31203, 16'h3B2A})
        ackDelay <= 8'd40;
        exec(16'h2D49);
        exec(16'h2D6E);
        `CHK({dmaReq, extOut}, {1'b1, 8'h6E})
        wait_idle();
        `CHK({lastWrite, lastAddr}, {1'b0, 18'h21203})
        exec(16'h0DA0);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        `CHK(rd[7:0], 8'hFC)
        // free run: 0 sets out byte, 1 jumps to page 3, 3FE sets out byte, 3FF loops on itself
        foreach (runAddr[i]) begin
            sel_addr(runAddr[i]);
            apb(1'b1, 12'h00C, {16'h0, runProg[i]}, 4'h3);
            apb(1'b1, 12'h000, 32'h2400, 4'h2);
        end
        apb(1'b1, 12'h000, 32'h8000, 4'h2);
        apb(1'b1, 12'h000, 32'h9000, 4'h2);
        apb(1'b0, 12'h00C, 32'h0, 4'h0);
        `CHK(rd, 32'hAFFF)
        `CHK({running, extOut}, {1'b1, 8'h67})
        end_sim();
    end
endmodule : tb_top
